/* hw/adc_seq_pkg.sv */
package adc_seq_pkg;

  // Data widths
  localparam int unsigned RES_W   = 10;  // Conversion value width
  localparam int unsigned NUM_RES = 12;  // Normal result registers
  localparam int unsigned NUM_MON = 2;   // Monitor channels

  // Register byte offsets
  localparam logic [7:0] OFS_MODE0    = 8'h00;  // mode_control_0
  localparam logic [7:0] OFS_MODE1    = 8'h04;  // mode_control_1
  localparam logic [7:0] OFS_MODE2    = 8'h08;  // mode_control_2
  localparam logic [7:0] OFS_MODE3    = 8'h0c;  // mode_control_3
  localparam logic [7:0] OFS_MODE5    = 8'h10;  // mode_control_5
  localparam logic [7:0] OFS_PRES     = 8'h14;  // priority_result
  localparam logic [7:0] OFS_CMP0     = 8'h18;  // monitor0_threshold
  localparam logic [7:0] OFS_CMP1     = 8'h1c;  // monitor1_threshold
  localparam logic [7:0] OFS_RES_BASE = 8'h20;  // Normal result 0
  localparam logic [7:0] OFS_RES_LAST = 8'h4c;  // Normal result 11
  localparam logic [4:0] RES_IDX_BASE = 5'h08;  // OFS_RES_BASE / 4

  // Result register fields
  localparam int unsigned RES_LSB   = 6;   // Value bits 15..6
  localparam int unsigned RES_MSB   = 15;
  localparam int unsigned OVR_BIT   = 1;   // Overrun flag
  localparam int unsigned VALID_BIT = 0;   // Stored flag

  // mode_control_0 fields
  localparam int unsigned M0_START   = 0;  // normal_start, write 1
  localparam int unsigned M0_SCAN    = 1;
  localparam int unsigned M0_REPEAT  = 2;
  localparam int unsigned M0_ITM_LSB = 3;  // repeat_irq_timing, 2 bits
  localparam int unsigned M0_BUSY    = 6;  // normal_busy_flag
  localparam int unsigned M0_END     = 7;  // Normal end flag

  // mode_control_1 fields
  localparam int unsigned M1_CH_LSB  = 0;  // channel_select, 4 bits
  localparam int unsigned M1_SCN_LSB = 4;  // scan_length_select, 2 bits
  localparam int unsigned M1_REF     = 7;  // reference_enable

  // mode_control_2 fields
  localparam int unsigned M2_HPCH_LSB = 0;  // priority_channel_select
  localparam int unsigned M2_HPSTART  = 4;  // Priority start, write 1
  localparam int unsigned M2_HPBUSY   = 5;  // priority_busy_flag
  localparam int unsigned M2_HPEND    = 6;  // priority_end_flag

  // mode_control_3 / mode_control_5 fields
  localparam int unsigned MC_EN      = 0;  // Monitor enable
  localparam int unsigned MC_DIR     = 1;  // 1 larger, 0 smaller
  localparam int unsigned MC_SEL_LSB = 2;  // Register select, 4 bits

  // Reset values
  localparam logic [7:0]       MODE_RST = 8'h00;
  localparam logic [RES_W-1:0] THR_RST  = 10'h000;

  // Scan group sizes and repeat interrupt unit
  localparam logic [3:0] SCAN_LEN_4  = 4'h4;
  localparam logic [3:0] SCAN_LEN_8  = 4'h8;
  localparam logic [3:0] SCAN_LEN_12 = 4'hc;
  localparam logic [3:0] ITM_EVERY   = 4'h1;

  // Normal conversion modes, {repeat, scan}
  typedef enum logic [1:0] {
    FIXED_SINGLE = 2'b00,
    SCAN_SINGLE  = 2'b01,
    FIXED_REPEAT = 2'b10,
    SCAN_REPEAT  = 2'b11
  } conv_mode_type;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_NORMAL,
    ST_PRIO
  } seq_state_type;

  // Monitor configuration
  typedef struct packed {
    logic [3:0] sel;
    logic       dir;
    logic       en;
  } monitor_cfg_type;

  // Request to the conversion core
  typedef struct packed {
    logic       start;
    logic       abort;
    logic [3:0] channel;
  } conv_req_type;

endpackage

/* hw/adc_sequencer_monitor.sv */
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// How it works
// - Priority value sits in bits 15..6
// - Overrun set on unread replace, read clears
// - Valid set on store, read clears
// - Two thresholds in bits 15..6, rest zero
// - Mode code: fixed/scan, single/repeat
// - Scan group holds 4, 8 or 12 channels
// - Fixed single: once, end, idle, interrupt
// - Scan single: whole group, then end, interrupt
// - Fixed repeat: busy stays, timed interrupt
// - Scan repeat: interrupt after each full scan
// - Priority request pre-empts normal conversion
// - Priority is one conversion of priority channel
// - Priority done: interrupt, end flag, idle
// - Priority request ignored while priority busy
// - Two monitors: enable, selector, direction, interrupt
// - Monitor compares on each watched store
// - Unread rewrite keeps valid and overrun set
// - Channel field picks input or scan base
// - Normal resumes at the interrupted channel
// - Selector 0..7 normal results, 1xxx priority
module adc_sequencer_monitor
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  logic               pclk,
  input  logic               presetn,
  // APB slave
  input  logic               psel,
  input  logic               penable,
  input  logic               pwrite,
  input  logic [7:0]         paddr,
  input  logic [31:0]        pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Conversion core
  output conv_req_type       conv_req,
  input  logic               conv_done,
  input  logic [RES_W-1:0]   conv_data,
  output logic               reference_enable,
  // Interrupt pulses
  output logic               normal_done_irq,
  output logic               priority_done_irq,
  output logic               monitor0_irq,
  output logic               monitor1_irq
);

  // Configuration registers
  logic [7:0]          mode0_ff;        // Scan, repeat, timing
  logic [7:0]          mode1_ff;        // Channel, scan length, ref
  logic [3:0]          hp_ch_ff;        // Priority channel
  monitor_cfg_type     mon_cfg_ff [NUM_MON];
  logic [RES_W-1:0]    thr_ff     [NUM_MON];
  // Sequencer state
  seq_state_type       state_ff;
  logic                n_busy_ff;       // normal_busy_flag
  logic                p_busy_ff;       // priority_busy_flag
  logic [3:0]          pos_ff;          // Position in scan group
  logic [3:0]          rep_ff;          // Fixed repeat counter
  conv_req_type        req_ff;
  logic                n_irq_ff;
  logic                p_irq_ff;
  // Store events
  logic                st_n_ff;         // Normal result stored
  logic                st_p_ff;         // Priority result stored
  logic [3:0]          st_idx_ff;
  logic [RES_W-1:0]    st_val_ff;
  // Result storage
  logic [RES_W-1:0]    res_ff   [NUM_RES];
  logic [NUM_RES-1:0]  rvld_ff;
  logic [NUM_RES-1:0]  rovr_ff;
  logic [RES_W-1:0]    pres_ff;
  logic                pvld_ff;
  logic                povr_ff;
  // End flags
  logic                n_end_ff;
  logic                p_end_ff;
  // Monitor pulses and read data
  logic [NUM_MON-1:0]  mon_irq_ff;
  logic [31:0]         prdata_ff;

  // Bus decode helpers
  logic                wr_en;
  logic                rd_setup;
  logic                in_res;
  logic [4:0]          res_widx;
  logic [3:0]          res_idx;
  logic                mapped;
  logic [31:0]         rd_mux;
  // Decoded mode values
  conv_mode_type       mode;
  logic                scan;
  logic [3:0]          scan_len;
  logic [3:0]          itm_target;
  logic                last;
  logic [3:0]          n_chan;

  // Zero-wait slave; flags clear when the setup cycle is sampled
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign in_res   = (paddr >= OFS_RES_BASE) && (paddr <= OFS_RES_LAST);
  assign res_widx = paddr[6:2] - RES_IDX_BASE;
  assign res_idx  = res_widx[3:0];

  // Address map check, word aligned only
  assign mapped = (paddr[1:0] == 2'b00) && ((paddr <= OFS_CMP1) || in_res);

  // Unmapped access errors in the access phase
  assign pslverr = psel & penable & ~mapped;

  // Mode decode from mode_control_0
  assign mode = conv_mode_type'(mode0_ff[M0_SCAN +: 2]);
  assign scan = mode0_ff[M0_SCAN];

  // Scan group size
  assign scan_len = (mode1_ff[M1_SCN_LSB +: 2] == 2'b00) ? SCAN_LEN_4
                  : (mode1_ff[M1_SCN_LSB +: 2] == 2'b01) ? SCAN_LEN_8
                  : SCAN_LEN_12;

  // Repeat interrupt every 1, 4, 8 or 12 conversions
  assign itm_target = (mode0_ff[M0_ITM_LSB +: 2] == 2'b00) ? ITM_EVERY
                    : {mode0_ff[M0_ITM_LSB +: 2], 2'b00};

  // Channel: fixed input, or scan base plus position
  assign last   = (pos_ff == (scan_len - 4'h1));
  assign n_chan = scan ? (mode1_ff[M1_CH_LSB +: 4] + pos_ff)
                       : mode1_ff[M1_CH_LSB +: 4];

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode0_ff <= MODE_RST;
      mode1_ff <= MODE_RST;
      hp_ch_ff <= MODE_RST[3:0];
      for (int i = 0; i < NUM_MON; i++) begin
        mon_cfg_ff[i] <= '0;
        thr_ff[i]     <= THR_RST;
      end
    end else if (wr_en) begin
      if (paddr == OFS_MODE0) begin
        // Start and status bits are not stored here
        mode0_ff <= {3'b000, pwdata[M0_ITM_LSB +: 2],
                     pwdata[M0_REPEAT], pwdata[M0_SCAN], 1'b0};
      end else if (paddr == OFS_MODE1) begin
        mode1_ff <= {pwdata[M1_REF], 1'b0,
                     pwdata[M1_SCN_LSB +: 2], pwdata[M1_CH_LSB +: 4]};
      end else if (paddr == OFS_MODE2) begin
        hp_ch_ff <= pwdata[M2_HPCH_LSB +: 4];
      end else if (paddr == OFS_MODE3) begin
        mon_cfg_ff[0] <= {pwdata[MC_SEL_LSB +: 4], pwdata[MC_DIR],
                          pwdata[MC_EN]};
      end else if (paddr == OFS_MODE5) begin
        mon_cfg_ff[1] <= {pwdata[MC_SEL_LSB +: 4], pwdata[MC_DIR],
                          pwdata[MC_EN]};
      end else if (paddr == OFS_CMP0) begin
        // Written while enabled too; software should disable first
        thr_ff[0] <= pwdata[RES_MSB:RES_LSB];
      end else if (paddr == OFS_CMP1) begin
        thr_ff[1] <= pwdata[RES_MSB:RES_LSB];
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= ST_IDLE;
      n_busy_ff <= 1'b0;
      p_busy_ff <= 1'b0;
      pos_ff    <= 4'h0;
      rep_ff    <= 4'h0;
      req_ff    <= '0;
      n_irq_ff  <= 1'b0;
      p_irq_ff  <= 1'b0;
      st_n_ff   <= 1'b0;
      st_p_ff   <= 1'b0;
      st_idx_ff <= 4'h0;
      st_val_ff <= THR_RST;
    end else begin
      // Pulses default low
      req_ff.start <= 1'b0;
      req_ff.abort <= 1'b0;
      n_irq_ff     <= 1'b0;
      p_irq_ff     <= 1'b0;
      st_n_ff      <= 1'b0;
      st_p_ff      <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // Priority is served first whenever pending
          if (p_busy_ff) begin
            req_ff.start   <= 1'b1;
            req_ff.channel <= hp_ch_ff;
            state_ff       <= ST_PRIO;
          end else if (n_busy_ff) begin
            req_ff.start   <= 1'b1;
            req_ff.channel <= n_chan;
            state_ff       <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (conv_done) begin
            // A result already done is kept even if pre-empted
            st_n_ff   <= 1'b1;
            st_val_ff <= conv_data;
            st_idx_ff <= scan ? pos_ff
                       : (mode0_ff[M0_REPEAT] ? rep_ff : 4'h0);
            state_ff  <= ST_IDLE;
            case (mode)
              FIXED_SINGLE: begin
                n_busy_ff <= 1'b0;
                n_irq_ff  <= 1'b1;
              end
              SCAN_SINGLE: begin
                if (last) begin
                  n_busy_ff <= 1'b0;
                  n_irq_ff  <= 1'b1;
                  pos_ff    <= 4'h0;
                end else begin
                  pos_ff <= pos_ff + 4'h1;
                end
              end
              FIXED_REPEAT: begin
                if (rep_ff >= (itm_target - 4'h1)) begin
                  n_irq_ff <= 1'b1;
                  rep_ff   <= 4'h0;
                end else begin
                  rep_ff <= rep_ff + 4'h1;
                end
              end
              default: begin
                if (last) begin
                  n_irq_ff <= 1'b1;
                  pos_ff   <= 4'h0;
                end else begin
                  pos_ff <= pos_ff + 4'h1;
                end
              end
            endcase
          end else if (p_busy_ff) begin
            // Drop the running channel; pos_ff keeps its place
            req_ff.abort <= 1'b1;
            state_ff     <= ST_IDLE;
          end
        end
        ST_PRIO: begin
          if (conv_done) begin
            st_p_ff   <= 1'b1;
            st_val_ff <= conv_data;
            p_irq_ff  <= 1'b1;
            p_busy_ff <= 1'b0;
            state_ff  <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      // Priority start only taken when none is in flight
      if (wr_en && (paddr == OFS_MODE2) && pwdata[M2_HPSTART]
          && !p_busy_ff) begin
        p_busy_ff <= 1'b1;
      end
      // Normal start restarts the group from its first channel
      if (wr_en && (paddr == OFS_MODE0) && pwdata[M0_START]) begin
        n_busy_ff <= 1'b1;
        pos_ff    <= 4'h0;
        rep_ff    <= 4'h0;
      end
    end
  end

  // Normal result registers; store beats a same-cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rvld_ff <= '0;
      rovr_ff <= '0;
      for (int i = 0; i < NUM_RES; i++) begin
        res_ff[i] <= THR_RST;
      end
    end else begin
      for (int i = 0; i < NUM_RES; i++) begin
        if (st_n_ff && (st_idx_ff == i[3:0])) begin
          res_ff[i]  <= st_val_ff;
          rvld_ff[i] <= 1'b1;
          rovr_ff[i] <= rovr_ff[i] | rvld_ff[i];
        end else if (rd_setup && in_res && (res_idx == i[3:0])) begin
          rvld_ff[i] <= 1'b0;
          rovr_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Priority result register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_ff <= THR_RST;
      pvld_ff <= 1'b0;
      povr_ff <= 1'b0;
    end else if (st_p_ff) begin
      pres_ff <= st_val_ff;
      pvld_ff <= 1'b1;
      povr_ff <= povr_ff | pvld_ff;
    end else if (rd_setup && (paddr == OFS_PRES)) begin
      pvld_ff <= 1'b0;
      povr_ff <= 1'b0;
    end
  end

  // End flags; a new completion wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_end_ff <= 1'b0;
      p_end_ff <= 1'b0;
    end else begin
      n_end_ff <= n_irq_ff
                | (n_end_ff & ~(rd_setup && (paddr == OFS_MODE0)));
      p_end_ff <= p_irq_ff
                | (p_end_ff & ~(rd_setup && (paddr == OFS_MODE2)));
    end
  end

  // Monitors compare each store into the watched register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_irq_ff <= '0;
    end else begin
      for (int m = 0; m < NUM_MON; m++) begin
        logic watched;
        logic beyond;
        if (mon_cfg_ff[m].sel[3]) begin
          watched = st_p_ff;
        end else begin
          watched = st_n_ff && (st_idx_ff == {1'b0, mon_cfg_ff[m].sel[2:0]});
        end
        // Strict compare, equal values never fire
        beyond = mon_cfg_ff[m].dir ? (st_val_ff > thr_ff[m])
                                   : (st_val_ff < thr_ff[m]);
        mon_irq_ff[m] <= mon_cfg_ff[m].en & watched & beyond;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == OFS_MODE0) begin
      rd_mux[7:0] = {n_end_ff, n_busy_ff, 1'b0, mode0_ff[4:0]};
    end else if (paddr == OFS_MODE1) begin
      rd_mux[7:0] = mode1_ff;
    end else if (paddr == OFS_MODE2) begin
      rd_mux[M2_HPCH_LSB +: 4] = hp_ch_ff;
      rd_mux[M2_HPBUSY]        = p_busy_ff;
      rd_mux[M2_HPEND]         = p_end_ff;
    end else if (paddr == OFS_MODE3) begin
      rd_mux[5:0] = mon_cfg_ff[0];
    end else if (paddr == OFS_MODE5) begin
      rd_mux[5:0] = mon_cfg_ff[1];
    end else if (paddr == OFS_PRES) begin
      rd_mux[RES_MSB:RES_LSB] = pres_ff;
      rd_mux[OVR_BIT]         = povr_ff;
      rd_mux[VALID_BIT]       = pvld_ff;
    end else if (paddr == OFS_CMP0) begin
      rd_mux[RES_MSB:RES_LSB] = thr_ff[0];
    end else if (paddr == OFS_CMP1) begin
      rd_mux[RES_MSB:RES_LSB] = thr_ff[1];
    end else if (in_res && (paddr[1:0] == 2'b00)) begin
      rd_mux[RES_MSB:RES_LSB] = res_ff[res_idx];
      rd_mux[OVR_BIT]         = rovr_ff[res_idx];
      rd_mux[VALID_BIT]       = rvld_ff[res_idx];
    end
  end

  // Read data captured in the setup cycle, held for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

  // Outputs
  assign prdata            = prdata_ff;
  assign conv_req          = req_ff;
  assign reference_enable  = mode1_ff[M1_REF];
  assign normal_done_irq   = n_irq_ff;
  assign priority_done_irq = p_irq_ff;
  assign monitor0_irq      = mon_irq_ff[0];
  assign monitor1_irq      = mon_irq_ff[1];

endmodule

/* verification/adc_core_model.sv */
`timescale 1ns/1ps
module adc_core_model
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  logic             pclk,
  input  logic             presetn,
  // Requests and timing
  input  conv_req_type     conv_req,
  input  int               dly,
  input  logic [RES_W-1:0] base,
  // Results
  output logic             conv_done,
  output logic [RES_W-1:0] conv_data,
  output logic [11:0]      ch_hist
);
  logic       busy;  // Conversion outstanding
  int         cnt;   // Cycles left
  logic [3:0] ch;    // Channel being converted

  // Data is only meaningful with the done pulse; toggle it otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 0;
      ch <= 4'h0;
      ch_hist <= 12'h000;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_req.start) begin
        busy <= 1'b1;
        cnt <= dly;
        ch <= conv_req.channel;
        ch_hist <= {ch_hist[7:0], conv_req.channel};
      end else if (conv_req.abort) begin
        busy <= 1'b0;  // Dropped, no result
      end else if (busy && cnt > 0) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= base + {6'h00, ch};
      end
    end
  end
endmodule

/* verification/adc_sequencer_monitor_assertions.sv */
`timescale 1ns/1ps
module adc_seq_checker
  import adc_seq_pkg::*;
(
  // Clock and reset
  input logic         pclk,
  input logic         presetn,
  // APB side
  input logic         psel,
  input logic         penable,
  input logic         pwrite,
  input logic [31:0]  prdata,
  // Core side
  input conv_req_type conv_req,
  input logic         conv_done,
  // Interrupt pulses
  input logic         normal_done_irq,
  input logic         priority_done_irq,
  input logic         monitor0_irq,
  input logic         monitor1_irq
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Aborted work must hand over to the priority channel at once
  property p_abort_start; conv_req.abort |=> conv_req.start; endproperty
  a_abort_start: assert property (p_abort_start)
    else $error("abort not followed by start");
  property p_norm_cause; normal_done_irq |-> $past(conv_done); endproperty
  a_norm_cause: assert property (p_norm_cause)
    else $error("normal irq without conversion");
  property p_prio_cause; priority_done_irq |-> $past(conv_done); endproperty
  a_prio_cause: assert property (p_prio_cause)
    else $error("priority irq without conversion");
  // One conversion ends either kind, never both
  property p_irq_excl; !(normal_done_irq && priority_done_irq); endproperty
  a_irq_excl: assert property (p_irq_excl)
    else $error("both completion irqs together");
  property p_prio_pulse; priority_done_irq |=> !priority_done_irq;
  endproperty
  a_prio_pulse: assert property (p_prio_pulse)
    else $error("priority irq longer than a pulse");
  // Monitors compare only on a fresh store
  property p_mon0_cause; monitor0_irq |-> $past(conv_done, 2); endproperty
  a_mon0_cause: assert property (p_mon0_cause)
    else $error("monitor 0 irq without store");
  property p_mon1_cause; monitor1_irq |-> $past(conv_done, 2); endproperty
  a_mon1_cause: assert property (p_mon1_cause)
    else $error("monitor 1 irq without store");
  property p_chan_hold; $changed(conv_req.channel) |-> conv_req.start;
  endproperty
  a_chan_hold: assert property (p_chan_hold)
    else $error("channel moved without start");
  // Read data may only move after a read setup edge
  property p_rdata_hold;
    $changed(prdata) |-> $past(psel && !penable && !pwrite);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a read");
endmodule

bind adc_sequencer_monitor adc_seq_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .conv_req(conv_req),
  .conv_done(conv_done), .normal_done_irq(normal_done_irq),
  .priority_done_irq(priority_done_irq),
  .monitor0_irq(monitor0_irq), .monitor1_irq(monitor1_irq)
);

/* verification/adc_sequencer_monitor_tb.sv */
`timescale 1ns/1ps
module adc_sequencer_monitor_tb;
  import adc_seq_pkg::*;
  // One register case: write, then read back
  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wd;
    logic [31:0] rexp;
    logic        eexp;
  } row_type;
  row_type rows [5] = '{
    '{OFS_CMP0, 32'hffffffff, 32'h0000ffc0, 1'b0},
    '{OFS_CMP1, 32'h12345678, 32'h00005640, 1'b0},
    '{OFS_PRES, 32'hffffffff, 32'h00000000, 1'b0},
    '{8'h50,    32'h00000001, 32'h00000000, 1'b1},
    '{8'h02,    32'h00000001, 32'h00000000, 1'b1}};
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rdv;
  conv_req_type conv_req;
  logic         conv_done, ref_en, erv;
  logic [9:0]   conv_data, base;
  logic [11:0]  ch_hist;
  logic [3:0]   irq;
  int           mismatches, compares, irq_cnt [4], ndone, snap, dly, t, nb;
  logic [7:0]   codes [4] = '{8'h00, 8'h02, 8'h04, 8'h06};
  int           dexp [4] = '{1, 4, 1, 4};
  // Status byte seen at the first completion of each mode
  logic [7:0]   sexp [4] = '{8'h80, 8'h82, 8'hc4, 8'hc6};

  always #20 pclk = ~pclk;

  adc_sequencer_monitor dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data), .reference_enable(ref_en),
    .normal_done_irq(irq[0]), .priority_done_irq(irq[1]),
    .monitor0_irq(irq[2]), .monitor1_irq(irq[3]));
  adc_core_model core_u (.pclk(pclk), .presetn(presetn),
    .conv_req(conv_req), .dly(dly), .base(base), .conv_done(conv_done),
    .conv_data(conv_data), .ch_hist(ch_hist));

  // Event counters, updated late so waits see settled counts
  always @(posedge pclk) begin
    if (conv_done === 1'b1) ndone <= ndone + 1;
    if (irq[0] === 1'b1) snap <= ndone;
    for (int i = 0; i < 4; i++)
      if (irq[i] === 1'b1) irq_cnt[i] <= irq_cnt[i] + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 4000) begin
      mismatches++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop;
    end
  endtask

  // APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 4000);
    hang(n);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_irq(input int i, input int tgt);
    int n;
    n = 0;
    while (irq_cnt[i] < tgt && n < 4000) begin @(posedge pclk); n++; end
    hang(n);
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; base = 10'h100; dly = 3;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then write and read back each row
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, rows[i].addr, 32'h0); check(rdv, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, rows[i].addr, rows[i].wd);
      apb(1'b0, rows[i].addr, 32'h0);
      check(rdv, rows[i].rexp);
      check({31'h0, erv}, {31'h0, rows[i].eexp});
    end
    apb(1'b1, OFS_MODE1, 32'h83);
    repeat (75) @(posedge pclk);
    check({31'h0, ref_en}, 32'h1);
    apb(1'b1, OFS_CMP0, {16'h0, 10'h105, 6'h0});
    apb(1'b1, OFS_CMP1, {16'h0, 10'h103, 6'h0});
    apb(1'b1, OFS_MODE3, 32'h23);
    apb(1'b1, OFS_MODE5, 32'h01);
    // Every normal mode; repeat modes stopped after two rounds
    for (int i = 0; i < 4; i++) begin
      t = irq_cnt[0];
      nb = ndone;
      apb(1'b1, OFS_MODE0, {24'h0, codes[i] | 8'h01});
      wait_irq(0, t + 1);
      check(snap - nb, dexp[i]);
      if (i == 1) check(ch_hist, 12'h456);
      apb(1'b0, OFS_MODE0, 32'h0);
      check(rdv & 32'hc6, sexp[i]);
      if (i == 0) begin
        apb(1'b0, OFS_RES_BASE, 32'h0);
        check(rdv, {16'h0, 10'h103, 6'h01});
      end
      if (codes[i][2]) begin
        wait_irq(0, t + 2);
        check(snap - nb, 2 * dexp[i]);
        apb(1'b1, OFS_MODE0, {24'h0, codes[i] & 8'h02});
      end
      t = 0;
      do begin apb(1'b0, OFS_MODE0, 32'h0); t++; end
      while (rdv[M0_BUSY] !== 1'b0 && t < 4000);
      hang(t);
    end
    // Priority, with a second request while busy
    dly <= 20;
    apb(1'b1, OFS_MODE2, 32'h1b);
    apb(1'b1, OFS_MODE2, 32'h1c);
    wait_irq(1, 1);
    repeat (40) @(posedge pclk);
    check(irq_cnt[1], 1);
    check(ch_hist[3:0], 4'hb);
    check(irq_cnt[2], 1);
    apb(1'b0, OFS_PRES, 32'h0);
    check(rdv, {16'h0, 10'h10b, 6'h01});
    for (int i = 2; i < 4; i++) begin
      apb(1'b1, OFS_MODE2, 32'h1b); wait_irq(1, i);
    end
    apb(1'b0, OFS_PRES, 32'h0);
    check(rdv, {16'h0, 10'h10b, 6'h03});
    apb(1'b0, OFS_PRES, 32'h0);
    check(rdv & 32'h3, 32'h0);
    // Priority cuts into a slow normal conversion
    dly <= 30;
    t = irq_cnt[0];
    apb(1'b1, OFS_MODE0, 32'h01);
    repeat (5) @(posedge pclk);
    apb(1'b1, OFS_MODE2, 32'h1a);
    wait_irq(0, t + 1);
    check(ch_hist, 12'h3a3);
    check(irq_cnt[3], 0);
    report_and_stop;
  end
endmodule
